// File: design/smac_top.sv
// SDRAM address derivation, control register and lane routing, with APB access
// ==========================================================
// Notes on behaviour
// R1: Row bits 0-10 from address 19..9
// R2: Row 11 from bit 7; row 12 by organisation
// R3: Column 7..0 from 20..27; column 8 by organisation
// R4: Bank 0 from bit 8; bank 1, columns 9/11
// R5: Line 10 never carries a column value
// R6: Shared bus; column LSB driven per DIMM
// R7: Enable bit gates all memory responses
// R8: Diagnostic mode suppresses machine check, still logs
// R9: Init status bit is read-only, shows completion
// R10: ECC mode 00 generates and checks normally
// R11: Mode 01 writes lane 0 into check byte
// R12: Mode 01 reads return check byte, no checking
// R13: Mode 10 disables checking, normal routing
// R14: Refresh to activate gap is field plus five
// R15: Software sets DRAM type field to 10
// R16: Software sets data pacing bit to 1
// R17: Mask mode: eight selects plus eight masks
// R18: Software enables mask mode for risky parts
// R19: Software keeps reserved bits at mandated values
// R20: Address bit 28 picks even or odd DIMM
// R21: Column latency 2, burst length 2
`timescale 1ns/100ps
`default_nettype none

module smac_top
  import smac_pkg::*;
#(
  parameter int DATA_W = 64
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic req_col_phase,
  input wire logic req_in_extent,
  input wire logic [31:0] req_addr,
  output logic [12:1] memory_address_bus,
  output logic even_column_lsb_line,
  output logic odd_column_lsb_line,
  output logic [1:0] bank_select,
  output logic odd_dimm_sel,
  output logic mem_accept,
  input wire logic init_done,
  input wire logic multi_bit_err,
  output logic machine_check,
  output logic err_log,
  input wire smac_word_t wr_in,
  input wire logic [7:0] wr_gen_ecc,
  output smac_word_t wr_out,
  input wire smac_word_t rd_in,
  output logic [63:0] rd_data,
  output logic ecc_check_en,
  input wire logic refresh_cmd,
  output logic activate_ok,
  input wire logic [15:0] cs_req,
  input wire logic [7:0] dqm_req,
  output logic [15:0] dimm_chip_selects,
  output logic [12:0] sdram_mode_word
);

  if (DATA_W != 64) begin : g_bad_width
    $error("smac_top: only a 64-bit data path is supported");
  end

  // ==========================================================
  // Register file
  logic [31:0] ctrl;
  logic [3:0] org;
  logic apb_wr;
  logic ctrl_hit;
  logic org_hit;
  logic [1:0] ecc_mode;
  logic [3:0] trc_cycles;

  assign ctrl_hit = (paddr[SMAC_APB_AW-1:0] == SMAC_CTRL_OFS) && (paddr[31:SMAC_APB_AW] == '0);
  assign org_hit = (paddr[SMAC_APB_AW-1:0] == SMAC_ORG_OFS) && (paddr[31:SMAC_APB_AW] == '0);
  assign apb_wr = psel && penable && pready && pwrite;
  assign ecc_mode = ctrl[SMAC_ECC_HI:SMAC_ECC_LO];
  assign trc_cycles = {1'b0, ctrl[SMAC_TRC_HI:SMAC_TRC_LO]} + SMAC_TRC_BASE; // R14

  // One wait-free access phase: pready rises in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !ctrl_hit && !org_hit;
      if (psel && !penable && !pwrite) begin
        if (ctrl_hit) begin
          // Status bit is live hardware state, never the stored copy
          prdata <= (ctrl & ~(32'h1 << SMAC_INIT_BIT)) | ({31'h0, init_done} << SMAC_INIT_BIT); // R9
        end else if (org_hit) begin
          prdata <= {28'h0, org};
        end else begin
          prdata <= '0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= SMAC_CTRL_RESET;
      org <= SMAC_ORG_RESET;
    end else if (apb_wr) begin
      if (ctrl_hit) begin
        // Read-only and reserved-zero positions are masked off
        ctrl <= pwdata & SMAC_CTRL_WMASK; // R9 R19
      end
      if (org_hit) begin
        org <= pwdata[3:0];
      end
    end
  end

  // ==========================================================
  // Address derivation
  smac_map_t map;
  logic [0:31] a_be;

  assign a_be = req_addr;

  smac_addr_map u_map (
    .sys_addr (req_addr),
    .org (org),
    .map (map)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_address_bus <= '0;
      even_column_lsb_line <= 1'b0;
      odd_column_lsb_line <= 1'b0;
      bank_select <= '0;
      odd_dimm_sel <= 1'b0;
    end else if (req_valid) begin
      bank_select <= map.bank; // R4
      odd_dimm_sel <= a_be[28]; // R20
      if (req_col_phase) begin
        // Line 10 is kept low: it is never a column address line
        memory_address_bus <= {1'b0, map.col[11], 1'b0, map.col[9:1]}; // R5
        // Odd DIMM gets the addressed column; the even DIMM wraps to its partner
        // word when the burst starts on the odd side, so the critical word leads
        odd_column_lsb_line <= map.col[0]; // R6
        even_column_lsb_line <= map.col[0] ^ a_be[28]; // R6
      end else begin
        memory_address_bus <= map.row[12:1]; // R1 R2
        odd_column_lsb_line <= map.row[0];
        even_column_lsb_line <= map.row[0];
      end
    end
  end

  // ==========================================================
  // Response gating and error signalling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_accept <= 1'b0;
      machine_check <= 1'b0;
      err_log <= 1'b0;
    end else begin
      mem_accept <= ctrl[SMAC_EN_BIT] && req_valid && req_in_extent; // R7
      machine_check <= multi_bit_err && !ctrl[SMAC_DIAG_BIT]; // R8
      err_log <= multi_bit_err; // R8
    end
  end

  // ==========================================================
  // ECC lane routing (byte lane 0 is the most significant byte)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_out <= '0;
      rd_data <= '0;
      ecc_check_en <= 1'b0;
    end else begin
      if (ecc_mode == SMAC_ECC_LANE) begin
        wr_out.data <= {8'h00, wr_in.data[55:0]}; // R11
        wr_out.ecc <= wr_in.data[63:56]; // R11
        rd_data <= {rd_in.ecc, rd_in.data[55:0]}; // R12
      end else begin
        wr_out.data <= wr_in.data; // R10 R13
        wr_out.ecc <= wr_gen_ecc; // R10 R13
        rd_data <= rd_in.data;
      end
      // Reserved mode 11 is treated as checking off, the safe choice
      ecc_check_en <= (ecc_mode == SMAC_ECC_NORMAL); // R10 R12 R13
    end
  end

  // ==========================================================
  // Refresh to activate spacing
  logic [3:0] trc_cnt;
  logic [3:0] next_trc_cnt;

  always_comb begin
    if (refresh_cmd) begin
      next_trc_cnt = trc_cycles - 4'h1;
    end else if (trc_cnt != 4'h0) begin
      next_trc_cnt = trc_cnt - 4'h1;
    end else begin
      next_trc_cnt = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trc_cnt <= 4'h0;
      activate_ok <= 1'b1;
    end else begin
      trc_cnt <= next_trc_cnt; // R14
      activate_ok <= (next_trc_cnt == 4'h0); // R14
    end
  end

  // ==========================================================
  // Chip selects, data mask and fixed mode word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dimm_chip_selects <= '0;
      sdram_mode_word <= '0;
    end else begin
      sdram_mode_word <= SMAC_MODE_WORD; // R21
      if (ctrl[SMAC_MASK_BIT]) begin
        dimm_chip_selects <= {dqm_req, cs_req[7:0]}; // R17
      end else begin
        dimm_chip_selects <= cs_req; // R17
      end
    end
  end

  // ==========================================================
  // Checks
  logic [4:0] gap_cnt;
  logic [3:0] gap_need;

  // The gap owed is fixed by the setting in force when the refresh went out,
  // so a later rewrite of the field cannot make a finished gap look short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_need <= SMAC_TRC_BASE;
    end else if (refresh_cmd) begin
      gap_need <= trc_cycles;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= 5'h1F;
    end else if (refresh_cmd) begin
      gap_cnt <= 5'h1;
    end else if (gap_cnt != 5'h1F) begin
      gap_cnt <= gap_cnt + 5'h1;
    end
  end

  a_row_low_bits: assert property (@(posedge pclk) disable iff (!presetn) // R1
    req_valid && !req_col_phase |=> memory_address_bus[10:1] ==
      {$past(req_addr[22]), $past(req_addr[21]), $past(req_addr[20]), $past(req_addr[19]),
       $past(req_addr[18]), $past(req_addr[17]), $past(req_addr[16]), $past(req_addr[15]),
       $past(req_addr[14]), $past(req_addr[13])})
    else $error("row address bits not taken from system address");

  a_row_eleven: assert property (@(posedge pclk) disable iff (!presetn) // R2
    req_valid && !req_col_phase && org <= SMAC_O12_8_1 |=> memory_address_bus[11] == $past(req_addr[24]))
    else $error("row bit 11 not from address bit 7");

  a_col_line10: assert property (@(posedge pclk) disable iff (!presetn) // R5
    req_valid && req_col_phase |=> !memory_address_bus[10])
    else $error("line 10 driven during column phase");

  a_col_lsb_pair: assert property (@(posedge pclk) disable iff (!presetn) // R6
    req_valid && req_col_phase |=> (even_column_lsb_line ^ odd_column_lsb_line) == $past(req_addr[3])
      && odd_column_lsb_line == $past(req_addr[4]))
    else $error("per-DIMM column LSB lines wrong");

  a_bank_dimm: assert property (@(posedge pclk) disable iff (!presetn) // R4
    req_valid |=> bank_select[0] == $past(req_addr[23]) && odd_dimm_sel == $past(req_addr[3]))
    else $error("bank 0 or DIMM select not from address");

  a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn) // R7
    !ctrl[SMAC_EN_BIT] && !$past(ctrl[SMAC_EN_BIT]) |-> ##1 !mem_accept)
    else $error("memory answered while disabled");

  a_diag_mcheck: assert property (@(posedge pclk) disable iff (!presetn) // R8
    multi_bit_err |=> err_log && (machine_check != $past(ctrl[SMAC_DIAG_BIT])))
    else $error("multi-bit error handling does not follow diagnostic mode");

  a_ecc_lane_wr: assert property (@(posedge pclk) disable iff (!presetn) // R11
    ecc_mode == SMAC_ECC_LANE |=> wr_out.data[63:56] == 8'h00 && wr_out.ecc == $past(wr_in.data[63:56]))
    else $error("lane 0 not routed into check byte");

  a_ecc_lane_rd: assert property (@(posedge pclk) disable iff (!presetn) // R12
    ecc_mode == SMAC_ECC_LANE |=> rd_data[63:56] == $past(rd_in.ecc) && !ecc_check_en)
    else $error("check byte not returned in lane 0");

  a_ecc_check: assert property (@(posedge pclk) disable iff (!presetn) // R10
    $past(presetn) |-> ecc_check_en == ($past(ecc_mode) == SMAC_ECC_NORMAL))
    else $error("checking enable disagrees with ECC mode");

  a_refresh_gap: assert property (@(posedge pclk) disable iff (!presetn) // R14
    activate_ok && !refresh_cmd && gap_cnt != 5'h1F |-> gap_cnt >= {1'b0, gap_need})
    else $error("activate allowed too early after refresh");

  a_mask_mode: assert property (@(posedge pclk) disable iff (!presetn) // R17
    ctrl[SMAC_MASK_BIT] |=> dimm_chip_selects[15:8] == $past(dqm_req))
    else $error("mask pins not driven in mask mode");

  a_select_plain: assert property (@(posedge pclk) disable iff (!presetn) // R17
    !ctrl[SMAC_MASK_BIT] |=> dimm_chip_selects == $past(cs_req))
    else $error("chip selects not passed through without mask mode");

  a_init_readback: assert property (@(posedge pclk) disable iff (!presetn) // R9
    psel && !penable && !pwrite && ctrl_hit |=> prdata[SMAC_INIT_BIT] == $past(init_done))
    else $error("init status bit does not show live state");

  a_col_low_bits: assert property (@(posedge pclk) disable iff (!presetn) // R3
    req_valid && req_col_phase |=> memory_address_bus[7:1] == $past(req_addr[11:5]))
    else $error("column bits 7..1 not taken from system address");

  a_refresh_hold: assert property (@(posedge pclk) disable iff (!presetn) // R14
    refresh_cmd |=> !activate_ok)
    else $error("activate allowed right after refresh");

  a_enable_accept: assert property (@(posedge pclk) disable iff (!presetn) // R7
    ctrl[SMAC_EN_BIT] && req_valid && req_in_extent |=> mem_accept)
    else $error("enabled memory did not answer");

  a_ecc_nocheck: assert property (@(posedge pclk) disable iff (!presetn) // R13
    ecc_mode == SMAC_ECC_NOCHECK |=> wr_out.data == $past(wr_in.data) && wr_out.ecc == $past(wr_gen_ecc))
    else $error("no-check mode altered write routing");

endmodule

`default_nettype wire

// File: design/smac_pkg.sv
// Shared constants and types of the SDRAM address map and control block
package smac_pkg;

  // ==========================================================
  // Register map
  localparam int SMAC_APB_AW = 12;
  localparam logic [11:0] SMAC_CTRL_OFS = 12'h000;
  localparam logic [11:0] SMAC_ORG_OFS = 12'h004;

  // ==========================================================
  // Control register fields (field n of the map sits at vector index 31-n)
  localparam int SMAC_EN_BIT = 31;
  localparam int SMAC_DIAG_BIT = 30;
  localparam int SMAC_INIT_BIT = 29;
  localparam int SMAC_ECC_HI = 28;
  localparam int SMAC_ECC_LO = 27;
  localparam int SMAC_TRC_HI = 26;
  localparam int SMAC_TRC_LO = 24;
  localparam int SMAC_MASK_BIT = 20;
  localparam logic [31:0] SMAC_CTRL_RESET = 32'h03A0_6000;
  localparam logic [31:0] SMAC_CTRL_WMASK = 32'hDFFF_FE03;
  localparam logic [3:0] SMAC_ORG_RESET = 4'h0;

  localparam logic [1:0] SMAC_ECC_NORMAL = 2'h0;
  localparam logic [1:0] SMAC_ECC_LANE = 2'h1;
  localparam logic [1:0] SMAC_ECC_NOCHECK = 2'h2;

  // ==========================================================
  // Timing
  localparam logic [3:0] SMAC_TRC_BASE = 4'h5;
  localparam logic [2:0] SMAC_CAS_LATENCY = 3'h2;
  localparam logic [2:0] SMAC_BURST_CODE = 3'h1;
  localparam logic [12:0] SMAC_MODE_WORD = {6'h00, SMAC_CAS_LATENCY, 1'b0, SMAC_BURST_CODE};

  // ==========================================================
  // Organisations, rows/columns/banks
  localparam logic [3:0] SMAC_O13_11_2 = 4'h0;
  localparam logic [3:0] SMAC_O13_10_2 = 4'h1;
  localparam logic [3:0] SMAC_O13_9_2 = 4'h2;
  localparam logic [3:0] SMAC_O13_10_1 = 4'h3;
  localparam logic [3:0] SMAC_O13_9_1 = 4'h4;
  localparam logic [3:0] SMAC_O13_8_2 = 4'h5;
  localparam logic [3:0] SMAC_O13_8_1 = 4'h6;
  localparam logic [3:0] SMAC_O12_10_2 = 4'h7;
  localparam logic [3:0] SMAC_O12_9_2 = 4'h8;
  localparam logic [3:0] SMAC_O12_8_2 = 4'h9;
  localparam logic [3:0] SMAC_O12_9_1 = 4'hA;
  localparam logic [3:0] SMAC_O12_8_1 = 4'hB;
  localparam logic [3:0] SMAC_O11_10_1 = 4'hC;
  localparam logic [3:0] SMAC_O11_9_1 = 4'hD;
  localparam logic [3:0] SMAC_O11_8_2 = 4'hE;
  localparam logic [3:0] SMAC_O11_8_1 = 4'hF;

  typedef struct packed {
    logic [12:0] row;
    logic [11:0] col;
    logic [1:0] bank;
  } smac_map_t;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0] ecc;
  } smac_word_t;

endpackage

// File: design/smac_addr_map.sv
// Split of a system address into SDRAM row, column and bank values
`timescale 1ns/100ps
`default_nettype none

module smac_addr_map
  import smac_pkg::*;
(
  input wire logic [0:31] sys_addr,
  input wire logic [3:0] org,
  output smac_map_t map
);

  always_comb begin
    map = '0;
    // Row bits 0..10 come from address 19 down to 9 for every part
    for (int i = 0; i <= 10; i++) begin
      map.row[i] = sys_addr[19 - i]; // R1
    end
    // Column bits 7..0 come from address 20..27
    for (int i = 0; i <= 7; i++) begin
      map.col[i] = sys_addr[27 - i]; // R3
    end
    map.bank[0] = sys_addr[8]; // R4
    case (org)
      SMAC_O13_11_2: begin
        map.row[12:11] = {sys_addr[4], sys_addr[7]}; // R2
        map.col[11] = sys_addr[2]; // R4
        map.col[9:8] = {sys_addr[3], sys_addr[6]}; // R3
        map.bank[1] = sys_addr[5];
      end
      SMAC_O13_10_2: begin
        map.row[12:11] = {sys_addr[4], sys_addr[7]}; // R2
        map.col[9:8] = {sys_addr[3], sys_addr[6]}; // R4
        map.bank[1] = sys_addr[5];
      end
      SMAC_O13_9_2: begin
        map.row[12:11] = {sys_addr[4], sys_addr[7]}; // R2
        map.col[8] = sys_addr[6]; // R3
        map.bank[1] = sys_addr[5];
      end
      SMAC_O13_10_1: begin
        map.row[12:11] = {sys_addr[4], sys_addr[7]}; // R2
        map.col[9:8] = {sys_addr[5], sys_addr[6]}; // R4
      end
      SMAC_O13_9_1: begin
        map.row[12:11] = {sys_addr[5], sys_addr[7]}; // R2
        map.col[8] = sys_addr[6];
      end
      SMAC_O13_8_2: begin
        map.row[12:11] = {sys_addr[6], sys_addr[7]}; // R2
        map.bank[1] = sys_addr[5];
      end
      SMAC_O13_8_1: begin
        map.row[12:11] = {sys_addr[6], sys_addr[7]}; // R2
      end
      SMAC_O12_10_2: begin
        map.row[11] = sys_addr[7];
        map.col[9:8] = {sys_addr[4], sys_addr[6]}; // R4
        map.bank[1] = sys_addr[5];
      end
      SMAC_O12_9_2: begin
        map.row[11] = sys_addr[7];
        map.col[8] = sys_addr[6];
        map.bank[1] = sys_addr[5];
      end
      SMAC_O12_8_2: begin
        map.row[11] = sys_addr[7];
        map.bank[1] = sys_addr[6]; // R4
      end
      SMAC_O12_9_1: begin
        map.row[11] = sys_addr[7];
        map.col[8] = sys_addr[6];
      end
      SMAC_O12_8_1: begin
        map.row[11] = sys_addr[7]; // R2
      end
      SMAC_O11_10_1: begin
        map.col[9:8] = {sys_addr[6], sys_addr[7]}; // R3
      end
      SMAC_O11_9_1: begin
        map.col[8] = sys_addr[7]; // R3
      end
      SMAC_O11_8_2: begin
        map.bank[1] = sys_addr[7]; // R4
      end
      default: begin
        map.bank[1] = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// File: test/smac_dimm_model.sv
// Behavioural pair of interleaved DIMMs on the far side of the block
`timescale 1ns/100ps
`default_nettype none

module smac_dimm_model
  import smac_pkg::*;
(
  input wire logic pclk,
  input wire logic odd_dimm_sel,
  input wire logic even_column_lsb_line,
  input wire logic odd_column_lsb_line,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire smac_word_t wr_out,
  output smac_word_t rd_in
);
  smac_word_t mem [0:3];
  smac_word_t last = '0;
  logic [1:0] idx;

  // ==========
  // Storage
  // Each DIMM uses its own column LSB line to pick a word of the two-beat burst
  assign idx = {odd_dimm_sel, odd_dimm_sel ? odd_column_lsb_line : even_column_lsb_line};

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[idx] <= wr_out;
    end
    if (rd_en) begin
      last <= mem[idx];
    end
  end

  // Released data lines float; the inverse keeps stale data from passing as a match
  assign rd_in = rd_en ? mem[idx] : smac_word_t'(~last);
endmodule

`default_nettype wire

// File: test/smac_top_tb_top.sv
// Self-checking bench of the SDRAM address map and control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end

module smac_top_tb_top
  import smac_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req_valid = 1'b0, req_col_phase = 1'b0, req_in_extent = 1'b0;
  logic init_done = 1'b0, multi_bit_err = 1'b0, refresh_cmd = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, req_addr = '0, prdata;
  logic pready, pslverr, even_column_lsb_line, odd_column_lsb_line, odd_dimm_sel, mem_accept;
  logic machine_check, err_log, ecc_check_en, activate_ok;
  logic [12:1] memory_address_bus;
  logic [1:0] bank_select;
  logic [7:0] wr_gen_ecc = '0, dqm_req = '0;
  logic [15:0] cs_req = '0, dimm_chip_selects;
  logic [12:0] sdram_mode_word;
  logic [63:0] rd_data;
  smac_word_t wr_in = '0, wr_out, rd_in;
  int fail_count = 0, total_checks = 0;
  localparam logic [31:0] CTRL_A = 32'(SMAC_CTRL_OFS);
  localparam logic [31:0] ORG_A = 32'(SMAC_ORG_OFS);
  // Source field per organisation, one nibble each: row12, col11, col9, col8, bank1 (0 = unused)
  localparam logic [19:0] SRC [16] = '{20'h42365, 20'h40365, 20'h40065, 20'h40560, 20'h50060, 20'h60005,
    20'h60000, 20'h00465, 20'h00065, 20'h00006, 20'h00060, 20'h00000, 20'h00670, 20'h00070, 20'h00007, 20'h00000};

  smac_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .req_valid, .req_col_phase, .req_in_extent, .req_addr, .memory_address_bus, .even_column_lsb_line,
    .odd_column_lsb_line, .bank_select, .odd_dimm_sel, .mem_accept, .init_done, .multi_bit_err, .machine_check,
    .err_log, .wr_in, .wr_gen_ecc, .wr_out, .rd_in, .rd_data, .ecc_check_en, .refresh_cmd, .activate_ok, .cs_req,
    .dqm_req, .dimm_chip_selects, .sdram_mode_word);
  smac_dimm_model far_end (.pclk, .odd_dimm_sel, .even_column_lsb_line, .odd_column_lsb_line, .wr_en, .rd_en,
    .wr_out, .rd_in);

  initial begin
    forever #4 pclk = ~pclk;
  end

  // ==========
  // Bus tasks
  task automatic tick();
    @(posedge pclk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    tick();
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    tick();
    penable <= 1'b1;
    n = 0;
    do begin
      tick();
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] ex, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, '0, q, e);
    `CHK("prdata", ex, q)
    `CHK("pslverr", ee, e)
  endtask

  // Software always keeps the type, pacing and reserved fields at their mandated values
  function automatic logic [31:0] cw(input logic en, input logic dg, input logic [1:0] ecc, input logic [2:0] trc,
    input logic mk);
    logic [31:0] v;
    v = 32'h00A0_6000;
    v[SMAC_EN_BIT] = en;
    v[SMAC_DIAG_BIT] = dg;
    v[SMAC_ECC_HI:SMAC_ECC_LO] = ecc;
    v[SMAC_TRC_HI:SMAC_TRC_LO] = trc;
    v[SMAC_MASK_BIT] = mk;
    return v;
  endfunction

  function automatic logic fb(input logic [31:0] a, input logic [3:0] k);
    return (k == 4'h0) ? 1'b0 : a[31 - k];
  endfunction

  // ==========
  // Scenarios
  // Row phase then column phase back to back from one system address
  task automatic map_chk(input logic [3:0] o, input logic [31:0] a, input logic en, input logic ext);
    logic [12:0] row;
    logic [11:0] col;
    logic [1:0] bk;
    row[10:0] = a[22:12];
    row[11] = (o < 4'hC) ? a[24] : 1'b0;
    row[12] = fb(a, SRC[o][19:16]);
    col = {fb(a, SRC[o][15:12]), 1'b0, fb(a, SRC[o][11:8]), fb(a, SRC[o][7:4]), a[11:4]};
    bk = {fb(a, SRC[o][3:0]), a[23]};
    tick();
    req_valid <= 1'b1;
    req_col_phase <= 1'b0;
    req_addr <= a;
    req_in_extent <= ext;
    tick();
    req_col_phase <= 1'b1;
    @(negedge pclk);
    `CHK("row bus", row[12:1], memory_address_bus)
    `CHK("even row lsb", row[0], even_column_lsb_line)
    `CHK("odd row lsb", row[0], odd_column_lsb_line)
    `CHK("bank", bk, bank_select)
    `CHK("dimm", a[3], odd_dimm_sel)
    `CHK("accept", en & ext, mem_accept)
    tick();
    req_valid <= 1'b0;
    @(negedge pclk);
    `CHK("col bus", {1'b0, col[11:1]}, memory_address_bus)
    `CHK("odd col lsb", col[0], odd_column_lsb_line)
    `CHK("even col lsb", col[0] ^ a[3], even_column_lsb_line)
  endtask

  // Write through the block into the far end and read it back
  task automatic ecc_chk(input logic [1:0] m);
    logic [63:0] d;
    d = 64'h9E37_79B9_7F4A_7C15 ^ {32{m}};
    wr_reg(CTRL_A, cw(1'b1, 1'b0, m, 3'h3, 1'b0));
    wr_in <= '{data: d, ecc: 8'h3C};
    wr_gen_ecc <= 8'h96;
    tick();
    @(negedge pclk);
    `CHK("wr_out", (m == 2'h1) ? {8'h00, d[55:0], d[63:56]} : {d, 8'h96}, wr_out)
    tick();
    wr_en <= 1'b1;
    tick();
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    tick();
    rd_en <= 1'b0;
    @(negedge pclk);
    `CHK("rd_data", d, rd_data)
    `CHK("ecc check", m == 2'h0, ecc_check_en)
  endtask

  task automatic refresh_chk(input logic [2:0] t);
    int n;
    wr_reg(CTRL_A, cw(1'b1, 1'b0, 2'h0, t, 1'b0));
    @(negedge pclk);
    `CHK("idle activate", 1'b1, activate_ok)
    tick();
    refresh_cmd <= 1'b1;
    tick();
    refresh_cmd <= 1'b0;
    n = 0;
    @(negedge pclk);
    while (activate_ok !== 1'b1 && n < 20) begin
      n++;
      @(negedge pclk);
    end
    `CHK("refresh gap", int'(t) + 4, n)
    if (n >= 20) begin
      fail_count++;
      give_verdict();
    end
  endtask

  // ==========
  // Main sequence
  initial begin
    logic [31:0] c;
    repeat (6) tick();
    presetn <= 1'b1;
    rd_chk(CTRL_A, SMAC_CTRL_RESET, 1'b0);
    init_done <= 1'b1;
    c = cw(1'b1, 1'b0, 2'h0, 3'h3, 1'b0);
    wr_reg(CTRL_A, c);
    rd_chk(CTRL_A, c | 32'h2000_0000, 1'b0);
    rd_chk(32'h0000_0008, 32'h0000_0000, 1'b1);
    `CHK("mode word", 13'h021, sdram_mode_word)
    for (int o = 0; o < 16; o++) begin
      wr_reg(ORG_A, 32'(o));
      wr_reg(CTRL_A, cw(o[0], 1'b0, 2'h0, 3'h3, 1'b0));
      map_chk(4'(o), 32'h5A3C_96E9, o[0], 1'b1);
      map_chk(4'(o), 32'hA5C3_6916, o[0], o[1]);
    end
    for (int d = 0; d < 2; d++) begin
      wr_reg(CTRL_A, cw(1'b1, d[0], 2'h0, 3'h3, 1'b0));
      multi_bit_err <= 1'b1;
      tick();
      multi_bit_err <= 1'b0;
      @(negedge pclk);
      `CHK("err log", 1'b1, err_log)
      `CHK("machine check", ~d[0], machine_check)
      @(negedge pclk);
      `CHK("check pulse", 1'b0, machine_check | err_log)
    end
    for (int m = 0; m < 3; m++) begin
      ecc_chk(2'(m));
    end
    refresh_chk(3'h0);
    refresh_chk(3'h7);
    for (int k = 0; k < 2; k++) begin
      wr_reg(CTRL_A, cw(1'b1, 1'b0, 2'h0, 3'h3, k[0]));
      cs_req <= 16'hC3A5;
      dqm_req <= 8'h5E;
      tick();
      @(negedge pclk);
      `CHK("selects", k[0] ? 16'h5EA5 : 16'hC3A5, dimm_chip_selects)
    end
    give_verdict();
  end
endmodule

`default_nettype wire
